// ===== common/rspsel_regs.svh
// Register offsets, field positions, select codes and reset values of the status pin select
`ifndef RSPSEL_REGS_SVH
`define RSPSEL_REGS_SVH
`define RSPSEL_ADDR_W 8
`define RSPSEL_DATA_W 32
`define RSPSEL_OFF_CTRL 8'h00
`define RSPSEL_OFF_PIN0 8'h04
`define RSPSEL_OFF_PIN1 8'h08
`define RSPSEL_OFF_PIN2 8'h0c
`define RSPSEL_OFF_STATUS 8'h10
`define RSPSEL_OFF_MASK 8'h14
`define RSPSEL_OFF_STATE 8'h18
`define RSPSEL_SEL_W 6
`define RSPSEL_CODE_COUNT 64
`define RSPSEL_PIN_INV_BIT 6
`define RSPSEL_CTRL_LEGACY_BIT 0
`define RSPSEL_CTRL_CCA_LSB 1
`define RSPSEL_CTRL_CCA_MSB 2
`define RSPSEL_EVT_W 4
`define RSPSEL_EVT_LOCK 0
`define RSPSEL_EVT_CRC 1
`define RSPSEL_EVT_SYNC 2
`define RSPSEL_EVT_DROP 3
`define RSPSEL_CODE_CCA 6'h09
`define RSPSEL_CODE_LOCK 6'h0a
`define RSPSEL_CODE_SCLK 6'h0b
`define RSPSEL_CODE_SDATA 6'h0c
`define RSPSEL_CODE_ASYNC 6'h0d
`define RSPSEL_CODE_CS 6'h0e
`define RSPSEL_CODE_CRC 6'h0f
`define RSPSEL_CODE_SYM1 6'h16
`define RSPSEL_CODE_SYM0 6'h17
`define RSPSEL_CODE_PAPD 6'h1b
`define RSPSEL_CODE_LNAPD 6'h1c
`define RSPSEL_CODE_TICK 6'h1d
`define RSPSEL_CODE_SYNC 6'h06
`define RSPSEL_CODE_LOW 6'h2f
`define RSPSEL_PIN_RESET 7'h00
`define RSPSEL_HALF_BIT_DEFAULT 4
`endif

// ===== common/rspsel_pkg.sv
// Types shared by the status pin select design
package rspsel_pkg;
	typedef enum logic [1:0] {
		RSPSEL_IDLE,
		RSPSEL_RX,
		RSPSEL_TX,
		RSPSEL_SLEEP
	} rspsel_radio_e;

	typedef enum logic [1:0] {
		RSPSEL_CCA_ALWAYS,
		RSPSEL_CCA_RSSI,
		RSPSEL_CCA_NOPKT,
		RSPSEL_CCA_BOTH
	} rspsel_cca_e;

	typedef struct packed {
		logic rssi_below_thr;
		logic rssi_above_thr;
		logic rx_packet_busy;
		logic pll_lock;
		logic sync_serial_active;
		logic rx_bit;
		logic rx_bit_valid;
		logic [1:0] rx_sliced_symbol;
		logic rx_symbol_tick;
		logic crc_done;
		logic crc_match;
		logic rx_enter;
		logic sync_found;
		logic packet_end;
		logic tx_underflow;
		logic rx_overflow;
		logic addr_fail;
	} rspsel_status_s;

	typedef struct packed {
		logic pin_output_invert;
		logic [5:0] sel;
	} rspsel_pin_cfg_s;
endpackage : rspsel_pkg

// ===== core/rspsel_pin_mux.sv
// One status pin: code select, optional inversion, registered pin output
`timescale 1ns/1ps
`include "rspsel_regs.svh"
module rspsel_pin_mux (
	input wire logic clk, // Core clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic [`RSPSEL_CODE_COUNT-1:0] src, // Candidate signal per select code
	input wire rspsel_pkg::rspsel_pin_cfg_s cfg, // Select code and inversion
	output logic pin // Registered pin level
);
	always_ff @(posedge clk) begin
		if (srst) begin
			pin <= 1'b0;
		end else begin
			pin <= src[cfg.sel] ^ cfg.pin_output_invert;
		end
	end

	pin_follows_a: assert property (@(posedge clk) disable iff (srst)
		##1 !$past(srst) |-> pin == ($past(src[cfg.sel]) ^ $past(cfg.pin_output_invert)))
		else $error("pin does not follow selected source");
endmodule : rspsel_pin_mux

// ===== core/rspsel_top.sv
// Radio status pin select: status sources, serial clocking, registers and interrupt
`timescale 1ns/1ps
`include "rspsel_regs.svh"
module rspsel_top #(
	parameter int PIN_COUNT = 3,
	parameter int HALF_BIT = `RSPSEL_HALF_BIT_DEFAULT
) (
	input wire logic clk, // Core clock, 100 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire rspsel_pkg::rspsel_status_s radio, // Radio status sources
	input wire rspsel_pkg::rspsel_radio_e radio_state, // Current radio state
	input wire logic [`RSPSEL_ADDR_W-1:0] addr, // Register byte address
	input wire logic [`RSPSEL_DATA_W-1:0] wdata, // Register write data
	input wire logic wr, // Write strobe
	input wire logic rd, // Read strobe
	output logic [`RSPSEL_DATA_W-1:0] rdata, // Read data, cycle after rd
	output logic irq, // Interrupt, level
	output logic [PIN_COUNT-1:0] general_status_pin // Status pins toward host
);
	localparam int CW = (HALF_BIT > 1) ? $clog2(HALF_BIT) : 1;
	localparam logic [CW-1:0] HALF_LAST = CW'(HALF_BIT - 1);
	// Bit-clock watch counter starts at one and holds one past the half period
	localparam logic [CW+1:0] SINCE_FIRST = (CW+2)'(1);
	localparam logic [CW+1:0] SINCE_DONE = (CW+2)'(HALF_BIT + 1);

	generate
		if (PIN_COUNT < 1 || PIN_COUNT > 3) begin : g_bad_pins
			$error("PIN_COUNT must be 1 to 3");
		end
		if (HALF_BIT < 1) begin : g_bad_half
			$error("HALF_BIT must be at least 1");
		end
	endgenerate

	rspsel_pkg::rspsel_pin_cfg_s pin_cfg [PIN_COUNT];
	logic legacy_compat_enable;
	rspsel_pkg::rspsel_cca_e channel_assess_mode;
	logic [`RSPSEL_EVT_W-1:0] status;
	logic [`RSPSEL_EVT_W-1:0] mask;
	logic lock_q;
	logic crc_ok;
	logic sync_state;
	logic ser_clk;
	logic ser_data;
	logic [CW-1:0] half_cnt;
	logic [CW+1:0] since_bit;
	logic [1:0] sym_hold;
	logic sym_strobe;
	logic chan_clear;
	logic sync_drop;
	logic [`RSPSEL_EVT_W-1:0] events;
	logic [`RSPSEL_CODE_COUNT-1:0] src;

	// Clear channel qualified by mode
	always_comb begin
		case (channel_assess_mode)
			rspsel_pkg::RSPSEL_CCA_ALWAYS: chan_clear = 1'b1;
			rspsel_pkg::RSPSEL_CCA_RSSI: chan_clear = radio.rssi_below_thr;
			rspsel_pkg::RSPSEL_CCA_NOPKT: chan_clear = !radio.rx_packet_busy;
			rspsel_pkg::RSPSEL_CCA_BOTH: chan_clear = radio.rssi_below_thr && !radio.rx_packet_busy;
			default: chan_clear = 1'b0;
		endcase
	end

	// Lock edge for the interrupt, the host's preferred way to see lock
	always_ff @(posedge clk) begin
		if (srst) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= radio.pll_lock;
		end
	end

	// Checksum match flag; a fresh receive entry clears it first
	always_ff @(posedge clk) begin
		if (srst) begin
			crc_ok <= 1'b0;
		end else if (radio.rx_enter) begin
			crc_ok <= 1'b0;
		end else if (radio.crc_done) begin
			crc_ok <= radio.crc_match;
		end
	end

	// Sync word status: drop on end of packet, on underflow in transmit, or on overflow or address fault in receive
	assign sync_drop = radio.packet_end
		|| (radio_state == rspsel_pkg::RSPSEL_TX && radio.tx_underflow)
		|| (radio_state == rspsel_pkg::RSPSEL_RX && (radio.addr_fail || radio.rx_overflow));

	always_ff @(posedge clk) begin
		if (srst) begin
			sync_state <= 1'b0;
		end else if (radio.sync_found) begin
			sync_state <= 1'b1;
		end else if (sync_drop) begin
			sync_state <= 1'b0;
		end
	end

	// Bit clock falls as each bit is loaded and rises half a period later,
	// so the host's rising edge lands mid-bit; a bit arriving before the
	// half period ends restarts the low phase, so the earlier bit gets no rising edge
	always_ff @(posedge clk) begin
		if (srst) begin
			ser_clk <= 1'b0;
			ser_data <= 1'b0;
			half_cnt <= '0;
		end else if (!radio.sync_serial_active) begin
			ser_clk <= 1'b0;
			half_cnt <= '0;
		end else if (radio.rx_bit_valid) begin
			ser_clk <= 1'b0;
			ser_data <= radio.rx_bit;
			half_cnt <= '0;
		end else if (!ser_clk) begin
			if (half_cnt == HALF_LAST) begin
				ser_clk <= 1'b1;
			end else begin
				half_cnt <= half_cnt + 1'b1;
			end
		end
	end

	// Sliced symbol held with a one-cycle strobe per symbol
	always_ff @(posedge clk) begin
		if (srst) begin
			sym_hold <= 2'h0;
			sym_strobe <= 1'b0;
		end else begin
			sym_strobe <= radio.rx_symbol_tick;
			if (radio.rx_symbol_tick) begin
				sym_hold <= radio.rx_sliced_symbol;
			end
		end
	end

	// Source vector per select code; unlisted and test codes read low
	always_comb begin
		src = '0;
		src[`RSPSEL_CODE_SYNC] = sync_state;
		src[`RSPSEL_CODE_CCA] = chan_clear;
		src[`RSPSEL_CODE_LOCK] = radio.pll_lock;
		src[`RSPSEL_CODE_SCLK] = ser_clk;
		src[`RSPSEL_CODE_SDATA] = ser_data;
		src[`RSPSEL_CODE_ASYNC] = radio.rx_bit;
		src[`RSPSEL_CODE_CS] = radio.rssi_above_thr;
		src[`RSPSEL_CODE_CRC] = crc_ok && legacy_compat_enable;
		src[`RSPSEL_CODE_SYM1] = sym_hold[1];
		src[`RSPSEL_CODE_SYM0] = sym_hold[0];
		src[`RSPSEL_CODE_TICK] = sym_strobe;
		src[`RSPSEL_CODE_PAPD] = !(radio_state == rspsel_pkg::RSPSEL_TX
			|| radio_state == rspsel_pkg::RSPSEL_SLEEP);
		src[`RSPSEL_CODE_LNAPD] = !(radio_state == rspsel_pkg::RSPSEL_RX
			|| radio_state == rspsel_pkg::RSPSEL_SLEEP);
		src[`RSPSEL_CODE_LOW] = 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			rspsel_pin_mux u_mux (
				.clk(clk),
				.srst(srst),
				.src(src),
				.cfg(pin_cfg[gi]),
				.pin(general_status_pin[gi])
			);
		end
	endgenerate

	// Control and pin configuration registers
	always_ff @(posedge clk) begin
		if (srst) begin
			legacy_compat_enable <= 1'b0;
			channel_assess_mode <= rspsel_pkg::RSPSEL_CCA_ALWAYS;
			for (int i = 0; i < PIN_COUNT; i++) begin
				pin_cfg[i] <= `RSPSEL_PIN_RESET;
			end
		end else if (wr) begin
			if (addr == `RSPSEL_OFF_CTRL) begin
				legacy_compat_enable <= wdata[`RSPSEL_CTRL_LEGACY_BIT];
				channel_assess_mode <= rspsel_pkg::rspsel_cca_e'(
					wdata[`RSPSEL_CTRL_CCA_MSB:`RSPSEL_CTRL_CCA_LSB]);
			end
			for (int i = 0; i < PIN_COUNT; i++) begin
				if (addr == `RSPSEL_OFF_PIN0 + 8'(4 * i)) begin
					pin_cfg[i] <= wdata[`RSPSEL_PIN_INV_BIT:0];
				end
			end
		end
	end

	assign events[`RSPSEL_EVT_LOCK] = radio.pll_lock && !lock_q;
	assign events[`RSPSEL_EVT_CRC] = radio.crc_done && radio.crc_match && !radio.rx_enter;
	assign events[`RSPSEL_EVT_SYNC] = radio.sync_found;
	assign events[`RSPSEL_EVT_DROP] = sync_state && sync_drop && !radio.sync_found;

	// Sticky status, write one to clear; a new event in the clearing cycle stays
	always_ff @(posedge clk) begin
		if (srst) begin
			status <= '0;
		end else if (wr && addr == `RSPSEL_OFF_STATUS) begin
			status <= (status & ~wdata[`RSPSEL_EVT_W-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mask <= '0;
		end else if (wr && addr == `RSPSEL_OFF_MASK) begin
			mask <= wdata[`RSPSEL_EVT_W-1:0];
		end
	end

	assign irq = |(status & mask);

	// Read data registered; unmapped addresses return zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= '0;
		end else if (rd) begin
			rdata <= '0;
			case (addr)
				`RSPSEL_OFF_CTRL: begin
					rdata[`RSPSEL_CTRL_LEGACY_BIT] <= legacy_compat_enable;
					rdata[`RSPSEL_CTRL_CCA_MSB:`RSPSEL_CTRL_CCA_LSB] <= channel_assess_mode;
				end
				`RSPSEL_OFF_STATUS: rdata[`RSPSEL_EVT_W-1:0] <= status;
				`RSPSEL_OFF_MASK: rdata[`RSPSEL_EVT_W-1:0] <= mask;
				`RSPSEL_OFF_STATE: rdata[PIN_COUNT-1:0] <= general_status_pin;
				default: begin
					for (int i = 0; i < PIN_COUNT; i++) begin
						if (addr == `RSPSEL_OFF_PIN0 + 8'(4 * i)) begin
							rdata[`RSPSEL_PIN_INV_BIT:0] <= pin_cfg[i];
						end
					end
				end
			endcase
		end else begin
			rdata <= '0;
		end
	end

	// Cycles since the last bit was loaded, saturating one past the half
	// period; lets the clock checks stand apart from the clock's own counter
	always_ff @(posedge clk) begin
		if (srst || !radio.sync_serial_active) begin
			since_bit <= '0;
		end else if (radio.rx_bit_valid) begin
			since_bit <= SINCE_FIRST;
		end else if (since_bit != '0 && since_bit != SINCE_DONE) begin
			since_bit <= since_bit + 1'b1;
		end
	end

	cca_rssi_a: assert property (@(posedge clk) disable iff (srst)
		channel_assess_mode == rspsel_pkg::RSPSEL_CCA_RSSI |-> src[`RSPSEL_CODE_CCA] == radio.rssi_below_thr)
		else $error("clear channel does not track signal strength");

	lock_source_a: assert property (@(posedge clk) disable iff (srst)
		src[`RSPSEL_CODE_LOCK] == radio.pll_lock)
		else $error("lock source wrong");

	clk_falls_a: assert property (@(posedge clk) disable iff (srst)
		radio.sync_serial_active && radio.rx_bit_valid |=> !ser_clk)
		else $error("bit clock did not fall on new bit");

	data_at_fall_a: assert property (@(posedge clk) disable iff (srst)
		$changed(ser_data) |-> !ser_clk)
		else $error("serial data changed while bit clock high");

	clk_rises_a: assert property (@(posedge clk) disable iff (srst)
		since_bit == SINCE_DONE |-> ser_clk)
		else $error("bit clock did not rise half a bit later");

	clk_low_a: assert property (@(posedge clk) disable iff (srst)
		since_bit != '0 && since_bit != SINCE_DONE |-> !ser_clk)
		else $error("bit clock high too early");

	async_source_a: assert property (@(posedge clk) disable iff (srst)
		src[`RSPSEL_CODE_ASYNC] == radio.rx_bit && src[`RSPSEL_CODE_CS] == radio.rssi_above_thr)
		else $error("transparent data or carrier sense source wrong");

	crc_clear_a: assert property (@(posedge clk) disable iff (srst)
		radio.rx_enter |=> !crc_ok)
		else $error("checksum flag not cleared on receive entry");

	symbol_hold_a: assert property (@(posedge clk) disable iff (srst)
		radio.rx_symbol_tick |=> sym_strobe && sym_hold == $past(radio.rx_sliced_symbol))
		else $error("symbol strobe or bits wrong");

	amp_sleep_a: assert property (@(posedge clk) disable iff (srst)
		radio_state == rspsel_pkg::RSPSEL_SLEEP |-> !src[`RSPSEL_CODE_PAPD] && !src[`RSPSEL_CODE_LNAPD])
		else $error("amplifier power-down level in sleep wrong");

	sync_drop_a: assert property (@(posedge clk) disable iff (srst)
		sync_state && sync_drop && !radio.sync_found |=> !sync_state ##1 1'b1)
		else $error("sync status did not drop");

	sync_rise_a: assert property (@(posedge clk) disable iff (srst)
		radio.sync_found |=> sync_state && status[`RSPSEL_EVT_SYNC])
		else $error("sync status did not rise");

	reserved_low_a: assert property (@(posedge clk) disable iff (srst)
		!src[6'h10] && !src[6'h12] && !src[6'h14])
		else $error("test code not low");

	cca_both_a: assert property (@(posedge clk) disable iff (srst)
		channel_assess_mode == rspsel_pkg::RSPSEL_CCA_BOTH
		|-> src[`RSPSEL_CODE_CCA] == (radio.rssi_below_thr && !radio.rx_packet_busy))
		else $error("clear channel does not follow both qualifiers");

	crc_load_a: assert property (@(posedge clk) disable iff (srst)
		radio.crc_done && !radio.rx_enter |=> crc_ok == $past(radio.crc_match))
		else $error("checksum flag not loaded from comparison");

	lock_event_a: assert property (@(posedge clk) disable iff (srst)
		radio.pll_lock && !lock_q |=> status[`RSPSEL_EVT_LOCK])
		else $error("lock rise not recorded");

	symbol_stable_a: assert property (@(posedge clk) disable iff (srst)
		!radio.rx_symbol_tick |=> sym_hold == $past(sym_hold))
		else $error("symbol bits moved without a strobe");

	sync_hold_a: assert property (@(posedge clk) disable iff (srst)
		sync_state && radio_state == rspsel_pkg::RSPSEL_TX && !radio.packet_end
		&& !radio.tx_underflow |=> sync_state)
		else $error("sync status dropped without cause in transmit");
endmodule : rspsel_top

// ===== tb/rspsel_host.sv
// Host model that samples the status pins the way a microcontroller would
`timescale 1ns/1ps
module rspsel_host (
	input wire logic clk, // Core clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic sclk_pin, // Bit clock pin
	input wire logic sdata_pin, // Serial data pin
	input wire logic lock_pin, // Lock detector pin
	output logic [7:0] shift, // Bits taken on rising clock edges
	output logic [7:0] lock_edges // Rising edges seen on the lock pin
);
	logic sclk_q;
	logic lock_q;
	always_ff @(posedge clk) begin
		sclk_q <= sclk_pin;
		lock_q <= lock_pin;
		if (srst) begin
			shift <= 8'h00;
			lock_edges <= 8'h00;
		end else begin
			if (sclk_pin && !sclk_q) begin
				shift <= {shift[6:0], sdata_pin};
			end
			// Lock is an edge event; a single level sample could miss it
			if (lock_pin && !lock_q) begin
				lock_edges <= lock_edges + 8'h01;
			end
		end
	end
endmodule : rspsel_host

// ===== tb/rspsel_bench.sv
// Self-checking bench of the status pin select with a host model
`timescale 1ns/1ps
`include "rspsel_regs.svh"
module rspsel_bench;
	localparam int HB = 3;
	logic clk, srst, wr, rd, irq;
	rspsel_pkg::rspsel_status_s radio, p;
	rspsel_pkg::rspsel_radio_e radio_state;
	logic [7:0] addr, shift, lock_edges, e8;
	logic [31:0] wdata, rdata, rng;
	logic [2:0] general_status_pin;
	logic [5:0] codes [11] = '{6'h09, 6'h0a, 6'h0d, 6'h0e, 6'h1b, 6'h1c, 6'h10, 6'h12, 6'h14,
		6'h2f, 6'h00};
	int bad_count, check_count, cycles, n;
	rspsel_top #(.PIN_COUNT(3), .HALF_BIT(HB)) rspsel_top_i (.clk(clk), .srst(srst),
		.radio(radio), .radio_state(radio_state), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .general_status_pin(general_status_pin));
	rspsel_host rspsel_host_i (.clk(clk), .srst(srst), .sclk_pin(general_status_pin[0]),
		.sdata_pin(general_status_pin[1]), .lock_pin(general_status_pin[2]),
		.shift(shift), .lock_edges(lock_edges));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	function automatic logic exp_pin(input logic [5:0] c, input rspsel_pkg::rspsel_status_s r,
		input rspsel_pkg::rspsel_radio_e s, input logic [1:0] m);
		case (c)
			6'h09: return (!m[0] || r.rssi_below_thr) && (!m[1] || !r.rx_packet_busy);
			6'h0a: return r.pll_lock;
			6'h0d: return r.rx_bit;
			6'h0e: return r.rssi_above_thr;
			6'h1b: return !(s == rspsel_pkg::RSPSEL_TX || s == rspsel_pkg::RSPSEL_SLEEP);
			6'h1c: return !(s == rspsel_pkg::RSPSEL_RX || s == rspsel_pkg::RSPSEL_SLEEP);
			default: return 1'b0;
		endcase
	endfunction : exp_pin
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
	endtask : rd_reg
	// Raises the given status bits for one cycle, then lets the pins settle
	task automatic pulse(input rspsel_pkg::rspsel_status_s q);
		@(posedge clk);
		radio <= rspsel_pkg::rspsel_status_s'(radio | q);
		@(posedge clk);
		radio <= rspsel_pkg::rspsel_status_s'(radio & ~q);
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic pin_is(input int k, input logic e);
		@(negedge clk);
		chk("pin", {31'h0, e}, {31'h0, general_status_pin[k]});
	endtask : pin_is
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		rspsel_pkg::rspsel_status_s r;
		srst = 1'b1;
		radio = '0;
		radio_state = rspsel_pkg::RSPSEL_IDLE;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		rng = 32'h35;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rd_reg(8'(a * 4), 32'h0);
		end
		rd_reg(`RSPSEL_OFF_PIN0, {25'h0, `RSPSEL_PIN_RESET});
		wr_reg(8'h1c, 32'hffffffff);
		rd_reg(8'h1c, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 88; i++) begin
			rng = xs(rng);
			wr_reg(`RSPSEL_OFF_CTRL, {29'h0, rng[1:0], 1'b0});
			wr_reg(`RSPSEL_OFF_PIN0, {25'h0, rng[2], codes[i % 11]});
			r = '0;
			r.rssi_below_thr = rng[3];
			r.rssi_above_thr = rng[4];
			r.rx_packet_busy = rng[5];
			r.pll_lock = rng[6];
			r.rx_bit = rng[7];
			@(posedge clk);
			radio <= r;
			radio_state <= rspsel_pkg::rspsel_radio_e'(rng[9:8]);
			repeat (2) @(posedge clk);
			pin_is(0, exp_pin(codes[i % 11], r, radio_state, rng[1:0]) ^ rng[2]);
		end
		$display("test code table done");
		wr_reg(`RSPSEL_OFF_PIN0, {26'h0, `RSPSEL_CODE_SCLK});
		wr_reg(`RSPSEL_OFF_PIN1, {26'h0, `RSPSEL_CODE_SDATA});
		rng = xs(rng);
		r = '0;
		r.sync_serial_active = 1'b1;
		@(posedge clk);
		radio <= r;
		for (int b = 7; b >= 0; b--) begin
			@(posedge clk);
			radio.rx_bit <= rng[b];
			radio.rx_bit_valid <= 1'b1;
			@(posedge clk);
			radio.rx_bit_valid <= 1'b0;
			repeat (2 * HB - 1) @(posedge clk);
		end
		@(negedge clk);
		chk("host byte", {24'h0, rng[7:0]}, {24'h0, shift});
		@(posedge clk);
		radio.sync_serial_active <= 1'b0;
		$display("test serial done");
		wr_reg(`RSPSEL_OFF_CTRL, 32'h1);
		rd_reg(`RSPSEL_OFF_CTRL, 32'h1);
		wr_reg(`RSPSEL_OFF_PIN0, {26'h0, `RSPSEL_CODE_CRC});
		p = '0;
		p.crc_done = 1'b1;
		p.crc_match = 1'b1;
		pulse(p);
		pin_is(0, 1'b1);
		p = '0;
		p.rx_enter = 1'b1;
		pulse(p);
		pin_is(0, 1'b0);
		p = '0;
		p.crc_done = 1'b1;
		p.crc_match = 1'b1;
		pulse(p);
		wr_reg(`RSPSEL_OFF_CTRL, 32'h0);
		@(posedge clk);
		pin_is(0, 1'b0);
		$display("test checksum done");
		wr_reg(`RSPSEL_OFF_PIN0, {26'h0, `RSPSEL_CODE_TICK});
		wr_reg(`RSPSEL_OFF_PIN1, {26'h0, `RSPSEL_CODE_SYM1});
		wr_reg(`RSPSEL_OFF_PIN2, {26'h0, `RSPSEL_CODE_SYM0});
		@(posedge clk);
		radio.rx_sliced_symbol <= 2'b10;
		radio.rx_symbol_tick <= 1'b1;
		@(posedge clk);
		radio.rx_symbol_tick <= 1'b0;
		radio.rx_sliced_symbol <= 2'b01;
		n = 0;
		repeat (6) @(negedge clk) n += general_status_pin[0];
		chk("strobe count", 32'h1, 32'(n));
		chk("held symbol", 32'h2, {30'h0, general_status_pin[1], general_status_pin[2]});
		$display("test symbol done");
		wr_reg(`RSPSEL_OFF_STATUS, 32'hf);
		wr_reg(`RSPSEL_OFF_MASK, 32'h4);
		wr_reg(`RSPSEL_OFF_PIN0, {26'h0, `RSPSEL_CODE_SYNC});
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			radio_state <= (k == 1) ? rspsel_pkg::RSPSEL_TX :
				((k > 1) ? rspsel_pkg::RSPSEL_RX : rspsel_pkg::RSPSEL_IDLE);
			p = '0;
			p.sync_found = 1'b1;
			pulse(p);
			pin_is(0, 1'b1);
			p = '0;
			if (k == 1) begin
				p.rx_overflow = 1'b1;
				pulse(p);
				pin_is(0, 1'b1);
				p = '0;
			end
			p.packet_end = (k == 0);
			p.tx_underflow = (k == 1);
			p.rx_overflow = (k == 2);
			p.addr_fail = (k == 3);
			pulse(p);
			pin_is(0, 1'b0);
		end
		@(negedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rd_reg(`RSPSEL_OFF_STATUS, 32'hc);
		wr_reg(`RSPSEL_OFF_STATUS, 32'h4);
		rd_reg(`RSPSEL_OFF_STATUS, 32'h8);
		chk("irq", 32'h0, {31'h0, irq});
		$display("test sync done");
		wr_reg(`RSPSEL_OFF_PIN2, {26'h0, `RSPSEL_CODE_LOCK});
		wr_reg(`RSPSEL_OFF_STATUS, 32'hf);
		wr_reg(`RSPSEL_OFF_MASK, 32'h1);
		e8 = lock_edges;
		@(posedge clk);
		radio.pll_lock <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("lock edges", {24'h0, e8 + 8'h01}, {24'h0, lock_edges});
		chk("irq", 32'h1, {31'h0, irq});
		wr_reg(`RSPSEL_OFF_STATUS, 32'h1);
		@(negedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr_reg(`RSPSEL_OFF_MASK, 32'h0);
		radio.pll_lock <= 1'b0;
		@(posedge clk);
		radio.pll_lock <= 1'b1;
		rd_reg(`RSPSEL_OFF_STATUS, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		rd_reg(`RSPSEL_OFF_PIN2, {26'h0, `RSPSEL_CODE_LOCK});
		rd_reg(`RSPSEL_OFF_STATE, 32'h6);
		$display("test lock done");
		report_and_stop();
	end
endmodule : rspsel_bench
